// file: hw/mfp1_pin_ctrl.sv
// Functional notes
// - Selector bits 7..4 reset to zero; zero means pin disabled.
// - Selector 0001 puts the ADC word clock on the pin.
// - Selectors 0010..0101 drive clock mux output divided by 1, 2, 4, 8.
// - 0110 drives short-circuit interrupt, 0111 drives AGC noise interrupt.
// - 1000 makes the pin an input, 1001 an output.
// - 1010 drives the digital microphone modulator clock.
// - 1011 makes the pin the bus word clock, input or output.
// - 1100 gives button interrupt, press time plus resolution, after delay.
// - 1101 jack detect, 1110 adds button, 1111 adds short and AGC.
// - Bit 3 picks clock mux source: PLL or clock divider mux.
// - Bit 2 clear gives one high pulse of about 2 ms per interrupt.
// - Bit 2 set repeats pulses until the flags register is read.
// - Read-only bit 1 shows the present pin level.
// - In output mode bit 0 sets the pin level.
// - Sticky flags register holds short, button, headset, AGC sources.
module mfp1_pin_ctrl
#(
    parameter int unsigned PULSE_CYC = mfp1_pkg::INT_PULSE_CYC,
    parameter int unsigned GAP_CYC = mfp1_pkg::INT_GAP_CYC,
    parameter int unsigned BTN_DELAY_CYC = mfp1_pkg::BTN_DELAY_CYC,
    parameter int unsigned BTN_RES_CYC = mfp1_pkg::BTN_RES_CYC
)
(
    input wire logic clock,
    input wire logic rstn,
    input wire logic [mfp1_pkg::REG_AW-1:0] reg_addr,
    input wire logic reg_wr,
    input wire logic [mfp1_pkg::REG_DW-1:0] reg_wdata,
    input wire logic reg_rd,
    output logic [mfp1_pkg::REG_DW-1:0] reg_rdata,
    input wire logic pll_clk,
    input wire logic clkdiv_mux_clk,
    input wire logic adc_wclk,
    input wire logic dmic_mod_clk,
    input wire logic bus_wclk,
    input wire logic bus_wclk_is_out,
    input wire logic [3:0] short_evt,
    input wire logic button_evt,
    input wire logic button_level,
    input wire logic headset_evt,
    input wire logic agc_noise_l_evt,
    input wire logic agc_noise_r_evt,
    input wire logic pin_in,
    output logic pin_out,
    output logic pin_oe_n,
    output logic pin_level
);
    import mfp1_pkg::*;

    localparam logic [TMR_W-1:0] DLY_LAST = TMR_W'(BTN_DELAY_CYC - 1);
    localparam logic [TMR_W-1:0] RES_LAST = TMR_W'(BTN_RES_CYC - 1);

    // Groups of interrupt sources each selector routes to the pulse stage
    function automatic logic [3:0] grp_mask(input mfp1_func_t fn);
        logic [3:0] m;
        m = 4'h0;
        unique case (fn)
            FN_SHORT_INT: m[GRP_SHORT] = 1'b1;
            FN_AGC_INT: m[GRP_AGC] = 1'b1;
            FN_HSD_INT: m[GRP_HSD] = 1'b1;
            FN_HSD_BTN_INT:
            begin
                m[GRP_HSD] = 1'b1;
                m[GRP_BTN] = 1'b1;
            end
            FN_ANY_INT: m = 4'hf;
            default: m = 4'h0;
        endcase
        return m;
    endfunction : grp_mask

    // Synchronisers: pin, PLL clock, divider mux clock
    logic [2:0] sync1_ff;
    logic [2:0] sync2_ff;
    logic [2:0] nxt_sync1;
    logic [2:0] nxt_sync2;

    always_comb
    begin
        nxt_sync1 = {clkdiv_mux_clk, pll_clk, pin_in};
        nxt_sync2 = sync1_ff;
    end

    always_ff @(posedge clock or negedge rstn)
    begin
        if (!rstn)
        begin
            sync1_ff <= 3'h0;
            sync2_ff <= 3'h0;
        end
        else
        begin
            sync1_ff <= nxt_sync1;
            sync2_ff <= nxt_sync2;
        end
    end

    logic pin_sync;
    assign pin_sync = sync2_ff[0];

    // Register file
    logic [REG_DW-1:0] ctrl_ff;
    logic [REG_DW-1:0] nxt_ctrl;
    logic [REG_DW-1:0] flags_ff;
    logic [REG_DW-1:0] nxt_flags;
    logic [REG_DW-1:0] rdata_ff;
    logic [REG_DW-1:0] nxt_rdata;
    logic [REG_DW-1:0] evt_vec;
    logic flags_rd;
    mfp1_func_t func;

    assign func = mfp1_func_t'(ctrl_ff[FUNC_LSB +: FUNC_W]);
    assign flags_rd = reg_rd && (reg_addr == FLAGS_ADDR);

    always_comb
    begin
        evt_vec = 8'h00;
        evt_vec[FLG_SHORT_LSB +: 4] = short_evt;
        evt_vec[FLG_BTN_BIT] = button_evt;
        evt_vec[FLG_HSD_BIT] = headset_evt;
        evt_vec[FLG_AGCL_BIT] = agc_noise_l_evt;
        evt_vec[FLG_AGCR_BIT] = agc_noise_r_evt;
        nxt_ctrl = ctrl_ff;
        if (reg_wr && (reg_addr == PIN1_CTRL_ADDR))
        begin
            nxt_ctrl = reg_wdata & CTRL_WMASK;
        end
        // A new event in the read cycle survives the clear
        nxt_flags = (flags_ff & ~{REG_DW{flags_rd}}) | evt_vec;
        nxt_rdata = rdata_ff;
        if (reg_rd)
        begin
            unique case (reg_addr)
                FLAGS_ADDR: nxt_rdata = flags_ff;
                PIN1_CTRL_ADDR:
                begin
                    nxt_rdata = ctrl_ff;
                    nxt_rdata[GPI_BIT] = pin_sync;
                end
                default: nxt_rdata = 8'h00;
            endcase
        end
    end

    always_ff @(posedge clock or negedge rstn)
    begin
        if (!rstn)
        begin
            ctrl_ff <= CTRL_RESET;
            flags_ff <= FLAGS_RESET;
            rdata_ff <= 8'h00;
        end
        else
        begin
            ctrl_ff <= nxt_ctrl;
            flags_ff <= nxt_flags;
            rdata_ff <= nxt_rdata;
        end
    end

    assign reg_rdata = rdata_ff;

    // Clock mux and divider; source sampled at 20 MHz, so slow clocks only
    logic mux_src;
    logic src_d_ff;
    logic nxt_src_d;
    logic [2:0] div_ff;
    logic [2:0] nxt_div;

    assign mux_src = ctrl_ff[MUX_SEL_BIT] ? sync2_ff[2] : sync2_ff[1];

    always_comb
    begin
        nxt_src_d = mux_src;
        nxt_div = div_ff;
        if (mux_src && !src_d_ff)
        begin
            nxt_div = div_ff + 3'h1;
        end
    end

    always_ff @(posedge clock or negedge rstn)
    begin
        if (!rstn)
        begin
            src_d_ff <= 1'b0;
            div_ff <= 3'h0;
        end
        else
        begin
            src_d_ff <= nxt_src_d;
            div_ff <= nxt_div;
        end
    end

    // Button interrupt: delay after press, stretched past release
    mfp1_btn_st_t btn_st_ff;
    mfp1_btn_st_t nxt_btn_st;
    logic [TMR_W-1:0] btn_cnt_ff;
    logic [TMR_W-1:0] nxt_btn_cnt;
    logic btn_int;

    always_comb
    begin
        nxt_btn_st = btn_st_ff;
        nxt_btn_cnt = btn_cnt_ff + TMR_W'(1);
        unique case (btn_st_ff)
            B_IDLE:
            begin
                nxt_btn_cnt = '0;
                if (button_level)
                begin
                    nxt_btn_st = B_WAIT;
                end
            end
            B_WAIT:
            begin
                if (!button_level)
                begin
                    nxt_btn_cnt = '0;
                    nxt_btn_st = B_IDLE;
                end
                else if (btn_cnt_ff == DLY_LAST)
                begin
                    nxt_btn_cnt = '0;
                    nxt_btn_st = B_ACT;
                end
            end
            B_ACT:
            begin
                nxt_btn_cnt = '0;
                if (!button_level)
                begin
                    nxt_btn_st = B_HOLD;
                end
            end
            B_HOLD:
            begin
                if (button_level)
                begin
                    nxt_btn_cnt = '0;
                    nxt_btn_st = B_ACT;
                end
                else if (btn_cnt_ff == RES_LAST)
                begin
                    nxt_btn_cnt = '0;
                    nxt_btn_st = B_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge clock or negedge rstn)
    begin
        if (!rstn)
        begin
            btn_st_ff <= B_IDLE;
            btn_cnt_ff <= '0;
        end
        else
        begin
            btn_st_ff <= nxt_btn_st;
            btn_cnt_ff <= nxt_btn_cnt;
        end
    end

    assign btn_int = (btn_st_ff == B_ACT) || (btn_st_ff == B_HOLD);

    // Interrupt pulse stage for the grouped sources
    logic [3:0] grp_evt;
    logic [3:0] grp_pend;
    logic [3:0] sel;
    logic int_trig;
    logic int_pend;
    logic int_pulse;

    always_comb
    begin
        grp_evt[GRP_SHORT] = |short_evt;
        grp_evt[GRP_AGC] = agc_noise_l_evt | agc_noise_r_evt;
        grp_evt[GRP_BTN] = button_evt;
        grp_evt[GRP_HSD] = headset_evt;
        grp_pend[GRP_SHORT] = |flags_ff[FLG_SHORT_LSB +: 4];
        grp_pend[GRP_AGC] = flags_ff[FLG_AGCL_BIT] | flags_ff[FLG_AGCR_BIT];
        grp_pend[GRP_BTN] = flags_ff[FLG_BTN_BIT];
        grp_pend[GRP_HSD] = flags_ff[FLG_HSD_BIT];
        sel = grp_mask(func);
        int_trig = |(grp_evt & sel);
        int_pend = |(grp_pend & sel);
    end

    mfp1_int_pulse #(
        .PULSE_CYC(PULSE_CYC),
        .GAP_CYC(GAP_CYC)
    ) u_int_pulse (
        .clock(clock),
        .rstn(rstn),
        .trig(int_trig),
        .cont_en(ctrl_ff[INT_CONT_BIT]),
        .pending(int_pend),
        .pulse(int_pulse)
    );

    // Pin driver, registered so the pad never sees mux glitches
    logic pin_out_ff;
    logic pin_oe_n_ff;
    logic nxt_pin_out;
    logic nxt_pin_oe_n;

    always_comb
    begin
        nxt_pin_out = 1'b0;
        nxt_pin_oe_n = 1'b0;
        unique case (func)
            FN_OFF: nxt_pin_oe_n = 1'b1;
            FN_ADC_WCLK: nxt_pin_out = adc_wclk;
            FN_DIV1: nxt_pin_out = mux_src;
            FN_DIV2: nxt_pin_out = div_ff[0];
            FN_DIV4: nxt_pin_out = div_ff[1];
            FN_DIV8: nxt_pin_out = div_ff[2];
            FN_SHORT_INT: nxt_pin_out = int_pulse;
            FN_AGC_INT: nxt_pin_out = int_pulse;
            FN_GPI: nxt_pin_oe_n = 1'b1;
            FN_GPO: nxt_pin_out = ctrl_ff[GPO_BIT];
            FN_DMIC_CLK: nxt_pin_out = dmic_mod_clk;
            FN_BUS_WCLK:
            begin
                nxt_pin_out = bus_wclk_is_out & bus_wclk;
                nxt_pin_oe_n = !bus_wclk_is_out;
            end
            FN_BTN_INT: nxt_pin_out = btn_int;
            FN_HSD_INT: nxt_pin_out = int_pulse;
            FN_HSD_BTN_INT: nxt_pin_out = int_pulse;
            FN_ANY_INT: nxt_pin_out = int_pulse;
        endcase
    end

    always_ff @(posedge clock or negedge rstn)
    begin
        if (!rstn)
        begin
            pin_out_ff <= 1'b0;
            pin_oe_n_ff <= 1'b1;
        end
        else
        begin
            pin_out_ff <= nxt_pin_out;
            pin_oe_n_ff <= nxt_pin_oe_n;
        end
    end

    assign pin_out = pin_out_ff;
    assign pin_oe_n = pin_oe_n_ff;
    // Synchronised pad level, e.g. incoming word clock in mode 1011
    assign pin_level = pin_sync;

endmodule : mfp1_pin_ctrl

// file: pkg/mfp1_pkg.sv
package mfp1_pkg;

    localparam int REG_AW = 8;
    localparam int REG_DW = 8;
    localparam int TMR_W = 17;

    localparam logic [REG_AW-1:0] FLAGS_ADDR = 8'h60;
    localparam logic [REG_AW-1:0] PIN1_CTRL_ADDR = 8'h62;

    localparam logic [REG_DW-1:0] CTRL_RESET = 8'h00;
    localparam logic [REG_DW-1:0] FLAGS_RESET = 8'h00;
    localparam logic [REG_DW-1:0] CTRL_WMASK = 8'hfd;

    localparam int FUNC_LSB = 4;
    localparam int FUNC_W = 4;
    localparam int MUX_SEL_BIT = 3;
    localparam int INT_CONT_BIT = 2;
    localparam int GPI_BIT = 1;
    localparam int GPO_BIT = 0;

    localparam int FLG_SHORT_LSB = 4;
    localparam int FLG_BTN_BIT = 3;
    localparam int FLG_HSD_BIT = 2;
    localparam int FLG_AGCL_BIT = 1;
    localparam int FLG_AGCR_BIT = 0;

    localparam int GRP_SHORT = 0;
    localparam int GRP_AGC = 1;
    localparam int GRP_BTN = 2;
    localparam int GRP_HSD = 3;

    localparam int CLK_MHZ = 20;
    localparam int INT_PULSE_US = 2000;
    localparam int INT_GAP_US = 2000;
    localparam int BTN_DELAY_US = 500;
    localparam int BTN_RES_US = 1000;
    localparam int INT_PULSE_CYC = INT_PULSE_US * CLK_MHZ;
    localparam int INT_GAP_CYC = INT_GAP_US * CLK_MHZ;
    localparam int BTN_DELAY_CYC = BTN_DELAY_US * CLK_MHZ;
    localparam int BTN_RES_CYC = BTN_RES_US * CLK_MHZ;

    typedef enum logic [3:0]
    {
        FN_OFF = 4'h0,
        FN_ADC_WCLK = 4'h1,
        FN_DIV1 = 4'h2,
        FN_DIV2 = 4'h3,
        FN_DIV4 = 4'h4,
        FN_DIV8 = 4'h5,
        FN_SHORT_INT = 4'h6,
        FN_AGC_INT = 4'h7,
        FN_GPI = 4'h8,
        FN_GPO = 4'h9,
        FN_DMIC_CLK = 4'ha,
        FN_BUS_WCLK = 4'hb,
        FN_BTN_INT = 4'hc,
        FN_HSD_INT = 4'hd,
        FN_HSD_BTN_INT = 4'he,
        FN_ANY_INT = 4'hf
    } mfp1_func_t;

    typedef enum logic [1:0]
    {
        P_IDLE = 2'b00,
        P_HIGH = 2'b01,
        P_GAP = 2'b10
    } mfp1_pulse_st_t;

    typedef enum logic [1:0]
    {
        B_IDLE = 2'b00,
        B_WAIT = 2'b01,
        B_ACT = 2'b10,
        B_HOLD = 2'b11
    } mfp1_btn_st_t;

endpackage : mfp1_pkg

// file: hw/mfp1_int_pulse.sv
module mfp1_int_pulse
#(
    parameter int unsigned PULSE_CYC = mfp1_pkg::INT_PULSE_CYC,
    parameter int unsigned GAP_CYC = mfp1_pkg::INT_GAP_CYC
)
(
    input wire logic clock,
    input wire logic rstn,
    input wire logic trig,
    input wire logic cont_en,
    input wire logic pending,
    output logic pulse
);
    import mfp1_pkg::*;

    localparam logic [TMR_W-1:0] HIGH_LAST = TMR_W'(PULSE_CYC - 1);
    localparam logic [TMR_W-1:0] GAP_LAST = TMR_W'(GAP_CYC - 1);

    mfp1_pulse_st_t st_ff;
    mfp1_pulse_st_t nxt_st;
    logic [TMR_W-1:0] cnt_ff;
    logic [TMR_W-1:0] nxt_cnt;

    always_comb
    begin
        nxt_st = st_ff;
        nxt_cnt = cnt_ff + TMR_W'(1);
        unique case (st_ff)
            P_IDLE:
            begin
                nxt_cnt = '0;
                // Repeat mode restarts while flags stay unread
                if (trig || (cont_en && pending))
                begin
                    nxt_st = P_HIGH;
                end
            end
            P_HIGH:
            begin
                // Events during a pulse merge into it
                if (cnt_ff == HIGH_LAST)
                begin
                    nxt_cnt = '0;
                    nxt_st = cont_en ? P_GAP : P_IDLE;
                end
            end
            P_GAP:
            begin
                if (cnt_ff == GAP_LAST)
                begin
                    nxt_cnt = '0;
                    nxt_st = P_IDLE;
                end
            end
            default:
            begin
                nxt_cnt = '0;
                nxt_st = P_IDLE;
            end
        endcase
    end

    always_ff @(posedge clock or negedge rstn)
    begin
        if (!rstn)
        begin
            st_ff <= P_IDLE;
            cnt_ff <= '0;
        end
        else
        begin
            st_ff <= nxt_st;
            cnt_ff <= nxt_cnt;
        end
    end

    assign pulse = (st_ff == P_HIGH);

endmodule : mfp1_int_pulse

// file: bench/mfp1_pin_ctrl_properties.sv
module mfp1_pin_ctrl_chk
#(
    parameter int unsigned PULSE_CYC = mfp1_pkg::INT_PULSE_CYC,
    parameter int unsigned GAP_CYC = mfp1_pkg::INT_GAP_CYC,
    parameter int unsigned BTN_DELAY_CYC = mfp1_pkg::BTN_DELAY_CYC,
    parameter int unsigned BTN_RES_CYC = mfp1_pkg::BTN_RES_CYC
)
(
    input wire logic clock,
    input wire logic rstn,
    input wire logic [mfp1_pkg::REG_AW-1:0] reg_addr,
    input wire logic reg_wr,
    input wire logic [mfp1_pkg::REG_DW-1:0] reg_wdata,
    input wire logic reg_rd,
    input wire logic [mfp1_pkg::REG_DW-1:0] reg_rdata,
    input wire logic adc_wclk,
    input wire logic dmic_mod_clk,
    input wire logic bus_wclk_is_out,
    input wire logic button_level,
    input wire logic pin_out,
    input wire logic pin_oe_n
);
    timeunit 1ns;
    timeprecision 1ns;
    import mfp1_pkg::*;
    logic [7:0] ctl_ff, nxt_ctl, hi_ff, nxt_hi;
    logic [1:0] age_ff, nxt_age;
    logic [3:0] fn;
    logic ok, int_md;
    assign fn = ctl_ff[7:4];
    // Pin follows a new selector only two edges after the write
    assign ok = (age_ff == 2'h3);
    assign int_md = fn inside {4'h6, 4'h7, 4'hd, 4'he, 4'hf};
    always_comb
    begin
        nxt_ctl = ctl_ff;
        nxt_age = ok ? age_ff : age_ff + 2'h1;
        nxt_hi = pin_out ? hi_ff + 8'h01 : 8'h00;
        if (reg_wr && reg_addr == PIN1_CTRL_ADDR)
        begin
            nxt_ctl = reg_wdata & CTRL_WMASK;
            nxt_age = 2'h0;
        end
    end
    always_ff @(posedge clock or negedge rstn)
    begin
        if (!rstn)
        begin
            ctl_ff <= 8'h00;
            age_ff <= 2'h3;
            hi_ff <= 8'h00;
        end
        else
        begin
            ctl_ff <= nxt_ctl;
            age_ff <= nxt_age;
            hi_ff <= nxt_hi;
        end
    end
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rstn);
    property p_off;
        ok && (fn == 4'h0 || fn == 4'h8) |-> pin_oe_n && !pin_out;
    endproperty
    a_off: assert property (p_off)
        else $error("pin driven while released");
    property p_gpo;
        ok && fn == 4'h9 |-> !pin_oe_n && pin_out == ctl_ff[0];
    endproperty
    a_gpo: assert property (p_gpo)
        else $error("output level differs from bit 0");
    property p_adc;
        ok && fn == 4'h1 |-> !pin_oe_n && pin_out == $past(adc_wclk);
    endproperty
    a_adc: assert property (p_adc)
        else $error("adc word clock not on pin");
    property p_dmic;
        ok && fn == 4'ha |-> !pin_oe_n && pin_out == $past(dmic_mod_clk);
    endproperty
    a_dmic: assert property (p_dmic)
        else $error("modulator clock not on pin");
    property p_wclk;
        ok && fn == 4'hb |-> pin_oe_n == !$past(bus_wclk_is_out);
    endproperty
    a_wclk: assert property (p_wclk)
        else $error("word clock direction wrong");
    property p_rd;
        reg_rd && reg_addr == PIN1_CTRL_ADDR
            |=> (reg_rdata & CTRL_WMASK) == $past(ctl_ff);
    endproperty
    a_rd: assert property (p_rd)
        else $error("control readback wrong");
    property p_unm;
        reg_rd && reg_addr != PIN1_CTRL_ADDR && reg_addr != FLAGS_ADDR
            |=> reg_rdata == 8'h00;
    endproperty
    a_unm: assert property (p_unm)
        else $error("unmapped read not zero");
    property p_len;
        ok && int_md && $fell(pin_out) |-> hi_ff == 8'(PULSE_CYC);
    endproperty
    a_len: assert property (p_len)
        else $error("interrupt pulse length wrong");
    property p_btn;
        (ok && fn == 4'hc) throughout (!button_level [*8]) |=> !pin_out;
    endproperty
    a_btn: assert property (p_btn)
        else $error("button interrupt outlasts release");
    c_gpo: cover property (ok && fn == 4'h9 && pin_out);
    c_pulse: cover property (ok && int_md && $fell(pin_out));
    c_btn: cover property (ok && fn == 4'hc && $rose(pin_out));
endmodule : mfp1_pin_ctrl_chk

bind mfp1_pin_ctrl mfp1_pin_ctrl_chk #(
    .PULSE_CYC(PULSE_CYC), .GAP_CYC(GAP_CYC),
    .BTN_DELAY_CYC(BTN_DELAY_CYC), .BTN_RES_CYC(BTN_RES_CYC)
) chk_u (
    .clock(clock), .rstn(rstn), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .adc_wclk(adc_wclk), .dmic_mod_clk(dmic_mod_clk),
    .bus_wclk_is_out(bus_wclk_is_out), .button_level(button_level),
    .pin_out(pin_out), .pin_oe_n(pin_oe_n)
);

// file: bench/mfp1_peer.sv
module mfp1_peer
(
    input wire logic clock,
    input wire logic rstn,
    input wire logic pin_out,
    input wire logic pin_oe_n,
    input wire logic drv_en,
    input wire logic drv_val,
    output logic pad
);
    timeunit 1ns;
    timeprecision 1ns;
    logic flt_ff;
    // Undriven pad wanders, so a stale level never reads as valid
    always_ff @(posedge clock or negedge rstn)
    begin
        if (!rstn)
            flt_ff <= 1'b0;
        else
            flt_ff <= !flt_ff;
    end
    // Device drive wins over the host side
    assign pad = !pin_oe_n ? pin_out : (drv_en ? drv_val : flt_ff);
endmodule : mfp1_peer

// file: bench/test_multifunction_pin_one_control.sv
module test_multifunction_pin_one_control;
    timeunit 1ns;
    timeprecision 1ns;
    import mfp1_pkg::*;
    logic clock = 1'b0;
    logic rstn = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic pll_clk = 1'b0;
    logic div_clk = 1'b0;
    logic adc_wclk = 1'b0;
    logic dmic_clk = 1'b0;
    logic bus_wclk = 1'b0;
    logic wclk_out = 1'b0;
    logic btn_lvl = 1'b0;
    logic [7:0] evt = 8'h00;
    logic drv_en = 1'b1;
    logic drv_val = 1'b0;
    logic [7:0] reg_rdata;
    logic pad, pin_out, pin_oe_n, pin_level;
    int fails = 0;
    int checked = 0;
    int cycles = 0;
    int gen = 0;
    initial forever #25 clock = !clock;
    // Two unrelated source clocks: periods of 16 and 24 cycles
    always @(posedge clock)
    begin
        gen <= gen + 1;
        if (gen % 8 == 7)
            pll_clk <= !pll_clk;
        if (gen % 12 == 11)
            div_clk <= !div_clk;
    end
    mfp1_pin_ctrl #(
        .PULSE_CYC(4), .GAP_CYC(8), .BTN_DELAY_CYC(3), .BTN_RES_CYC(5)
    ) dut_u (
        .clock(clock), .rstn(rstn), .reg_addr(reg_addr), .reg_wr(reg_wr),
        .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .pll_clk(pll_clk), .clkdiv_mux_clk(div_clk), .adc_wclk(adc_wclk),
        .dmic_mod_clk(dmic_clk), .bus_wclk(bus_wclk),
        .bus_wclk_is_out(wclk_out), .short_evt(evt[7:4]),
        .button_evt(evt[3]), .button_level(btn_lvl), .headset_evt(evt[2]),
        .agc_noise_l_evt(evt[1]), .agc_noise_r_evt(evt[0]), .pin_in(pad),
        .pin_out(pin_out), .pin_oe_n(pin_oe_n), .pin_level(pin_level)
    );
    mfp1_peer peer_u (
        .clock(clock), .rstn(rstn), .pin_out(pin_out),
        .pin_oe_n(pin_oe_n), .drv_en(drv_en), .drv_val(drv_val), .pad(pad)
    );
    task automatic finish_test;
        $display("checked %0d fails %0d", checked, fails);
        if (fails == 0 && checked > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : finish_test
    task automatic chk(input string nm, input logic [7:0] seen,
        input logic [7:0] exp);
        checked++;
        if (seen !== exp)
        begin
            fails++;
            $display("ERROR %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk
    task automatic cyc(input int n);
        repeat (n) @(posedge clock);
    endtask : cyc
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clock);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clock);
        reg_wr <= 1'b0;
    endtask : wr
    task automatic rc(input logic [7:0] a, input logic [7:0] e,
        input string nm);
        @(posedge clock);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clock);
        reg_rd <= 1'b0;
        #1;
        chk(nm, reg_rdata, e);
    endtask : rc
    // Width of the next high pulse; zero if none comes within 40 cycles
    task automatic pw(output int w);
        int t;
        t = 0;
        w = 0;
        while (pin_out !== 1'b1 && t < 40)
        begin
            @(posedge clock);
            t++;
        end
        while (pin_out === 1'b1 && w < 60)
        begin
            @(posedge clock);
            w++;
        end
    endtask : pw
    task automatic per(output int p);
        logic last;
        int n;
        last = 1'b1;
        n = 0;
        p = 0;
        while (n < 2 && p < 600)
        begin
            @(posedge clock);
            if (n > 0)
                p++;
            if (pin_out === 1'b1 && last === 1'b0)
                n++;
            last = pin_out;
        end
    endtask : per
    task automatic t_regs;
        rc(PIN1_CTRL_ADDR, 8'h00, "ctrl reset");
        chk("oe_n off", pin_oe_n, 8'h01);
        rc(8'h61, 8'h00, "unmapped");
        wr(FLAGS_ADDR, 8'hff);
        rc(FLAGS_ADDR, 8'h00, "flags ro");
    endtask : t_regs
    task automatic t_gpio;
        drv_en <= 1'b0;
        wr(PIN1_CTRL_ADDR, 8'h91);
        cyc(4);
        chk("gpo high", {pin_oe_n, pin_out}, 8'h01);
        rc(PIN1_CTRL_ADDR, 8'h93, "ctrl level");
        wr(PIN1_CTRL_ADDR, 8'h92);
        cyc(4);
        chk("gpo low", {pin_oe_n, pin_out}, 8'h00);
        rc(PIN1_CTRL_ADDR, 8'h90, "ctrl ro bit");
        // Release the device first, so the pad never has two drivers
        wr(PIN1_CTRL_ADDR, 8'h80);
        cyc(3);
        drv_en <= 1'b1;
        drv_val <= 1'b1;
        cyc(5);
        rc(PIN1_CTRL_ADDR, 8'h82, "gpi level");
        chk("gpi oe_n", pin_oe_n, 8'h01);
        chk("pin level", pin_level, 8'h01);
    endtask : t_gpio
    task automatic t_clk;
        drv_en <= 1'b0;
        adc_wclk <= 1'b1;
        wr(PIN1_CTRL_ADDR, 8'h10);
        cyc(4);
        chk("adc wclk", {pin_oe_n, pin_out}, 8'h01);
        wr(PIN1_CTRL_ADDR, 8'ha0);
        cyc(4);
        chk("dmic low", {pin_oe_n, pin_out}, 8'h00);
        dmic_clk <= 1'b1;
        cyc(3);
        chk("dmic high", {pin_oe_n, pin_out}, 8'h01);
        wclk_out <= 1'b1;
        bus_wclk <= 1'b1;
        wr(PIN1_CTRL_ADDR, 8'hb0);
        cyc(4);
        chk("wclk out", {pin_oe_n, pin_out}, 8'h01);
        wclk_out <= 1'b0;
        cyc(3);
        chk("wclk in", pin_oe_n, 8'h01);
    endtask : t_clk
    task automatic t_div;
        int p;
        for (int k = 0; k < 4; k++)
        begin
            wr(PIN1_CTRL_ADDR, {4'(k + 2), 4'h0});
            cyc(4);
            per(p);
            chk("div period", 8'(p), 8'(16 << k));
        end
        wr(PIN1_CTRL_ADDR, 8'h38);
        cyc(4);
        per(p);
        chk("div source", 8'(p), 8'h30);
    endtask : t_div
    task automatic t_int;
        logic [3:0] md [10] = '{4'h6, 4'h7, 4'h7, 4'hd, 4'he,
            4'he, 4'hf, 4'hf, 4'h6, 4'hd};
        int bt [10] = '{7, 1, 0, 2, 3, 2, 4, 0, 1, 3};
        int w;
        // Last two entries pick a source outside the selected group
        for (int i = 0; i < 10; i++)
        begin
            wr(PIN1_CTRL_ADDR, {md[i], 4'h0});
            cyc(3);
            evt <= 8'h01 << bt[i];
            @(posedge clock);
            evt <= 8'h00;
            pw(w);
            chk("pulse", 8'(w), (i < 8) ? 8'h04 : 8'h00);
            rc(FLAGS_ADDR, 8'h01 << bt[i], "flags");
            rc(FLAGS_ADDR, 8'h00, "flags clear");
        end
    endtask : t_int
    task automatic t_cont;
        int w;
        wr(PIN1_CTRL_ADDR, 8'hf4);
        cyc(3);
        evt <= 8'h08;
        @(posedge clock);
        evt <= 8'h00;
        pw(w);
        chk("cont first", 8'(w), 8'h04);
        pw(w);
        chk("cont again", 8'(w), 8'h04);
        rc(FLAGS_ADDR, 8'h08, "flags");
        pw(w);
        chk("cont stop", 8'(w), 8'h00);
    endtask : t_cont
    task automatic t_btn;
        int w;
        wr(PIN1_CTRL_ADDR, 8'hc0);
        cyc(3);
        btn_lvl <= 1'b1;
        cyc(2);
        btn_lvl <= 1'b0;
        pw(w);
        chk("btn short", 8'(w), 8'h00);
        btn_lvl <= 1'b1;
        cyc(12);
        chk("btn held", pin_out, 8'h01);
        btn_lvl <= 1'b0;
        pw(w);
        chk("btn tail", 8'(w >= 4 && w <= 8), 8'h01);
    endtask : t_btn
    always @(posedge clock)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            fails++;
            finish_test();
        end
    end
    initial
    begin
        repeat (6) @(posedge clock);
        rstn <= 1'b1;
        t_regs();
        t_gpio();
        t_clk();
        t_div();
        t_int();
        t_cont();
        t_btn();
        finish_test();
    end
endmodule : test_multifunction_pin_one_control
